//--- src/cbm_core_ports.sv
module cbm_core_ports
    import cbm_pkg::*;
(
    // Clock and resets
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              debug_reset_in,
    input  wire logic              external_break_in,
    input  wire logic              external_nonmaskable_break_in,
    input  wire logic              interrupt_in,
    // Bus side
    cbm_if.core                    bus,
    // Data peripheral request
    input  wire logic              dp_req,
    input  wire logic              dp_rnw,
    input  wire logic              dp_lock,
    input  wire logic              dp_seq,
    input  wire logic [ADDR_W-1:0] dp_addr,
    input  wire logic [BE_W-1:0]   dp_be,
    input  wire logic [DATA_W-1:0] dp_wdata,
    output logic                   dp_busy,
    output logic                   dp_done,
    output logic                   dp_err,
    output logic [DATA_W-1:0]      dp_rdata,
    // Fetch peripheral request
    input  wire logic              fp_req,
    input  wire logic [ADDR_W-1:0] fp_addr,
    output logic                   fp_busy,
    output logic                   fp_done,
    output logic                   fp_err,
    output logic [DATA_W-1:0]      fp_rdata,
    // Data local request
    input  wire logic              dl_req,
    input  wire logic              dl_rnw,
    input  wire logic [ADDR_W-1:0] dl_addr,
    input  wire logic [BE_W-1:0]   dl_be,
    input  wire logic [DATA_W-1:0] dl_wdata,
    output logic                   dl_ready,
    output logic                   dl_done,
    output logic [DATA_W-1:0]      dl_rdata,
    // Fetch local request
    input  wire logic              fl_req,
    input  wire logic [ADDR_W-1:0] fl_addr,
    output logic                   fl_ready,
    output logic                   fl_done,
    output logic [DATA_W-1:0]      fl_rdata,
    // Debug state seen by the core
    output logic                   halt_pending,
    output logic                   irq_seen
);
    // ==========================================================
    // Debug inputs, synchronised
    logic       srst;
    logic [3:0] dbg_s1_r, dbg_s2_r;
    always_ff @(posedge clk) begin
        dbg_s1_r <= {debug_reset_in, external_break_in, external_nonmaskable_break_in,
                     interrupt_in}; // R15
        dbg_s2_r <= dbg_s1_r;
    end
    assign srst = rst | dbg_s2_r[3]; // R15
    always_ff @(posedge clk) begin
        if (srst) halt_pending <= 1'b0;
        else if (dbg_s2_r[1] | dbg_s2_r[2]) halt_pending <= 1'b1; // R15
    end
    always_ff @(posedge clk) begin
        if (srst) irq_seen <= 1'b0;
        else irq_seen <= dbg_s2_r[0];
    end

    // ==========================================================
    // Peripheral masters: byte-enable sizing only, no other sizing path
    typedef enum logic [1:0] {
        CBM_P_IDLE = 2'b00,
        CBM_P_REQ  = 2'b01,
        CBM_P_XFER = 2'b10
    } cbm_pst_e;
    cbm_pst_e dp_st_r, fp_st_r;

    // Data peripheral
    always_ff @(posedge clk) begin // R1 R2
        if (srst) begin
            dp_st_r <= CBM_P_IDLE;
            bus.dside_master_request <= 1'b0;
            bus.dside_master_select <= 1'b0;
            bus.dside_master_lock <= 1'b0;
            bus.dside_master_sequential <= 1'b0;
            bus.dside_master_read_not_write <= 1'b0;
            bus.dside_master_address <= ADDR_RST;
            bus.dside_master_byte_enables <= BE_NONE;
            bus.dside_master_write_data <= FETCH_WDATA;
            {dp_done, dp_err} <= 2'h0;
            dp_rdata <= FETCH_WDATA;
        end else begin
            dp_done <= 1'b0;
            dp_err  <= 1'b0;
            case (dp_st_r)
                CBM_P_IDLE: begin
                    if (dp_req) begin
                        bus.dside_master_request        <= 1'b1;
                        bus.dside_master_lock           <= dp_lock;
                        bus.dside_master_address        <= dp_addr;
                        bus.dside_master_byte_enables   <= dp_be; // R2
                        bus.dside_master_read_not_write <= dp_rnw;
                        bus.dside_master_write_data     <= dp_rnw ? FETCH_WDATA : dp_wdata; // R5
                        bus.dside_master_sequential     <= dp_seq;
                        dp_st_r                         <= CBM_P_REQ;
                    end
                end
                CBM_P_REQ: begin
                    if (bus.dside_grant_in) begin
                        bus.dside_master_request <= 1'b0;
                        bus.dside_master_select  <= 1'b1;
                        dp_st_r                  <= CBM_P_XFER;
                    end
                end
                CBM_P_XFER: begin
                    if (bus.dside_transfer_ack_in | bus.dside_error_ack_in |
                        bus.dside_timeout_in) begin
                        bus.dside_master_select     <= 1'b0;
                        bus.dside_master_lock       <= 1'b0;
                        bus.dside_master_sequential <= 1'b0;
                        dp_done                     <= 1'b1;
                        dp_err  <= bus.dside_error_ack_in | bus.dside_timeout_in;
                        dp_rdata <= bus.dside_read_data_in; // R5
                        dp_st_r  <= CBM_P_IDLE;
                    end else if (bus.dside_retry_in) begin
                        // Retry drops the cycle and re-arbitrates with same request
                        bus.dside_master_select  <= 1'b0;
                        bus.dside_master_request <= 1'b1;
                        dp_st_r                  <= CBM_P_REQ;
                    end
                end
                default: dp_st_r <= CBM_P_IDLE;
            endcase
        end
    end
    assign dp_busy = (dp_st_r != CBM_P_IDLE);

    // Fetch peripheral: read only, write bus constant
    assign bus.fside_master_write_data     = FETCH_WDATA; // R3
    assign bus.fside_master_read_not_write = FETCH_RNW;   // R4
    assign bus.fside_master_byte_enables   = BE_WORD;     // R2
    assign bus.fside_master_lock           = 1'b0;
    always_ff @(posedge clk) begin // R1
        if (srst) begin
            fp_st_r <= CBM_P_IDLE;
            bus.fside_master_request <= 1'b0;
            bus.fside_master_select <= 1'b0;
            bus.fside_master_sequential <= 1'b0;
            bus.fside_master_address <= ADDR_RST;
            {fp_done, fp_err} <= 2'h0;
            fp_rdata <= FETCH_WDATA;
        end else begin
            fp_done <= 1'b0;
            fp_err  <= 1'b0;
            case (fp_st_r)
                CBM_P_IDLE: begin
                    if (fp_req) begin
                        bus.fside_master_request <= 1'b1;
                        bus.fside_master_address <= fp_addr;
                        fp_st_r                  <= CBM_P_REQ;
                    end
                end
                CBM_P_REQ: begin
                    if (bus.fside_grant_in) begin
                        bus.fside_master_request <= 1'b0;
                        bus.fside_master_select  <= 1'b1;
                        fp_st_r                  <= CBM_P_XFER;
                    end
                end
                CBM_P_XFER: begin
                    if (bus.fside_transfer_ack_in | bus.fside_error_ack_in |
                        bus.fside_timeout_in) begin
                        bus.fside_master_select <= 1'b0;
                        fp_done  <= 1'b1;
                        fp_err   <= bus.fside_error_ack_in | bus.fside_timeout_in;
                        fp_rdata <= bus.fside_read_data_in;
                        fp_st_r  <= CBM_P_IDLE;
                    end else if (bus.fside_retry_in) begin
                        bus.fside_master_select  <= 1'b0;
                        bus.fside_master_request <= 1'b1;
                        fp_st_r                  <= CBM_P_REQ;
                    end
                end
                default: fp_st_r <= CBM_P_IDLE;
            endcase
        end
    end
    assign fp_busy = (fp_st_r != CBM_P_IDLE);

    // ==========================================================
    // Data local port; all strobes high true
    logic dl_act_r, dl_rnw_r;
    // Start in the done cycle keeps the strobe high back to back
    assign dl_ready = ~dl_act_r | bus.local_data_done; // R18
    logic dl_start;
    assign dl_start = dl_req & dl_ready & cbm_be_legal(dl_be); // R13
    always_ff @(posedge clk) begin // R8 R10
        if (srst) begin
            dl_act_r                    <= 1'b0;
            dl_rnw_r                    <= 1'b0;
            bus.local_data_addr_strobe  <= 1'b0;
            bus.local_data_address      <= ADDR_RST;
            bus.local_data_byte_enables <= BE_NONE;
            bus.local_data_write        <= FETCH_WDATA;
        end else begin
            bus.local_data_addr_strobe <= dl_start; // R16
            if (dl_start) begin
                dl_act_r                    <= 1'b1;
                dl_rnw_r                    <= dl_rnw;
                bus.local_data_address      <= dl_addr; // R11
                bus.local_data_byte_enables <= dl_be;   // R12 R13
                bus.local_data_write        <= dl_wdata; // R19
            end else if (dl_act_r & bus.local_data_done) begin
                dl_act_r <= 1'b0; // R17
            end
        end
    end
    // Strobes drop after the ready edge, so one-cycle memory gives one-cycle access
    assign bus.local_data_read_strobe  = dl_act_r & dl_rnw_r;  // R18 R9
    assign bus.local_data_write_strobe = dl_act_r & ~dl_rnw_r; // R18
    assign dl_done  = dl_act_r & bus.local_data_done;         // R17
    assign dl_rdata = bus.local_data_read;

    // ==========================================================
    // Fetch local port: read only, fetch strobe
    logic fl_act_r;
    assign fl_ready = ~fl_act_r | bus.local_fetch_done;
    always_ff @(posedge clk) begin // R14 R8
        if (srst) begin
            fl_act_r                    <= 1'b0;
            bus.local_fetch_addr_strobe <= 1'b0;
            bus.local_fetch_address     <= ADDR_RST;
        end else begin
            bus.local_fetch_addr_strobe <= fl_req & fl_ready; // R16
            if (fl_req & fl_ready) begin
                fl_act_r                <= 1'b1;
                bus.local_fetch_address <= fl_addr; // R11
            end else if (bus.local_fetch_done) begin
                fl_act_r <= 1'b0;
            end
        end
    end
    // Back-to-back fetches keep the strobe high: one fetch per clock
    assign bus.local_fetch_in_progress = fl_act_r; // R14 R18 R9
    assign fl_done  = fl_act_r & bus.local_fetch_done; // R17
    assign fl_rdata = bus.local_fetch_instr;
endmodule

//--- src/cbm_fabric_end.sv
module cbm_fabric_end
    import cbm_pkg::*;
#(
    parameter int WAIT_D = 1
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Bus side
    cbm_if.fabric                  bus,
    // Shared slave memory port (user side)
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [BE_W-1:0]        mem_be,
    output logic [DATA_W-1:0]      mem_wdata,
    input  wire logic [DATA_W-1:0] mem_rdata,
    // Monitor view
    output logic [DATA_W-1:0]      monitor_data
);
    // ==========================================================
    // Monitor data: read and write buses ORed
    assign monitor_data = bus.dside_master_write_data | bus.dside_read_data_in; // R6

    // ==========================================================
    // Multi-ported slave: data side wins over fetch side
    logic d_own_r, f_own_r, d_gnt, f_gnt;
    assign d_gnt = bus.dside_master_request & ~f_own_r & ~d_own_r;
    assign f_gnt = bus.fside_master_request & ~bus.dside_master_request & ~d_own_r & ~f_own_r;
    always_ff @(posedge clk) begin // R7
        if (rst) begin
            d_own_r <= 1'b0;
            f_own_r <= 1'b0;
        end else begin
            if (d_gnt) d_own_r <= 1'b1;
            else if (bus.dside_transfer_ack_in) d_own_r <= 1'b0;
            if (f_gnt) f_own_r <= 1'b1;
            else if (bus.fside_transfer_ack_in) f_own_r <= 1'b0;
        end
    end
    assign bus.dside_grant_in = d_gnt; // R7
    assign bus.fside_grant_in = f_gnt;
    assign mem_addr  = f_own_r ? bus.fside_master_address : bus.dside_master_address;
    assign mem_be    = f_own_r ? bus.fside_master_byte_enables
                               : bus.dside_master_byte_enables;
    assign mem_wdata = bus.dside_master_write_data;
    assign mem_we    = d_own_r & bus.dside_master_select & ~bus.dside_master_read_not_write
                       & bus.dside_transfer_ack_in;
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.dside_transfer_ack_in <= 1'b0;
            bus.fside_transfer_ack_in <= 1'b0;
            bus.dside_read_data_in    <= FETCH_WDATA;
            bus.fside_read_data_in    <= FETCH_WDATA;
        end else begin
            bus.dside_transfer_ack_in <= d_own_r & bus.dside_master_select
                                         & ~bus.dside_transfer_ack_in;
            bus.fside_transfer_ack_in <= f_own_r & bus.fside_master_select
                                         & ~bus.fside_transfer_ack_in;
            bus.dside_read_data_in <= (d_own_r & bus.dside_master_read_not_write)
                                      ? mem_rdata : FETCH_WDATA;
            bus.fside_read_data_in <= f_own_r ? mem_rdata : FETCH_WDATA;
        end
    end
    assign {bus.dside_error_ack_in, bus.dside_retry_in, bus.dside_timeout_in} = 3'h0;
    assign {bus.fside_error_ack_in, bus.fside_retry_in, bus.fside_timeout_in} = 3'h0;

    // ==========================================================
    // Local block RAM controllers; memory array lives here
    logic [DATA_W-1:0] ram_r [0:255];
    logic [7:0]        d_idx, f_idx;
    assign d_idx = bus.local_data_address[9:2];
    assign f_idx = bus.local_fetch_address[9:2];
    // Data side answers one cycle after the strobe (two clocks per write)
    always_ff @(posedge clk) begin // R9 R17
        if (rst) begin
            bus.local_data_done <= 1'b0;
            bus.local_data_read <= FETCH_WDATA;
        end else begin
            bus.local_data_done <= bus.local_data_addr_strobe;
            bus.local_data_read <= ram_r[d_idx];
        end
    end
    // One process owns the array; lanes are split inside it
    always_ff @(posedge clk) begin // R13
        for (int g = 0; g < BE_W; g++) begin
            if (bus.local_data_addr_strobe & bus.local_data_write_strobe &
                bus.local_data_byte_enables[BE_W-1-g])
                ram_r[d_idx][DATA_W-1-8*g -: 8] <= bus.local_data_write[DATA_W-1-8*g -: 8];
        end
    end
    // Fetch side raises done in the strobe cycle itself; the registered instruction comes a cycle later
    assign bus.local_fetch_done  = bus.local_fetch_in_progress; // R9 R17
    always_ff @(posedge clk) begin
        if (rst) bus.local_fetch_instr <= FETCH_WDATA;
        else     bus.local_fetch_instr <= ram_r[f_idx];
    end
endmodule

//--- src/cbm_if.sv
interface cbm_if
    import cbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst
);
    // Data-side peripheral master
    logic [ADDR_W-1:0] dside_master_address;
    logic [BE_W-1:0]   dside_master_byte_enables;
    logic              dside_master_lock;
    logic [DATA_W-1:0] dside_master_write_data;
    logic              dside_master_request;
    logic              dside_master_read_not_write;
    logic              dside_master_select;
    logic              dside_master_sequential;
    logic [DATA_W-1:0] dside_read_data_in;
    logic              dside_error_ack_in;
    logic              dside_grant_in;
    logic              dside_retry_in;
    logic              dside_timeout_in;
    logic              dside_transfer_ack_in;
    // Fetch-side peripheral master
    logic [ADDR_W-1:0] fside_master_address;
    logic [BE_W-1:0]   fside_master_byte_enables;
    logic              fside_master_lock;
    logic [DATA_W-1:0] fside_master_write_data;
    logic              fside_master_request;
    logic              fside_master_read_not_write;
    logic              fside_master_select;
    logic              fside_master_sequential;
    logic [DATA_W-1:0] fside_read_data_in;
    logic              fside_error_ack_in;
    logic              fside_grant_in;
    logic              fside_retry_in;
    logic              fside_timeout_in;
    logic              fside_transfer_ack_in;
    // Data-side local port
    logic [ADDR_W-1:0] local_data_address;
    logic [BE_W-1:0]   local_data_byte_enables;
    logic [DATA_W-1:0] local_data_write;
    logic              local_data_addr_strobe;
    logic              local_data_read_strobe;
    logic              local_data_write_strobe;
    logic [DATA_W-1:0] local_data_read;
    logic              local_data_done;
    // Fetch-side local port
    logic [ADDR_W-1:0] local_fetch_address;
    logic              local_fetch_addr_strobe;
    logic              local_fetch_in_progress;
    logic [DATA_W-1:0] local_fetch_instr;
    logic              local_fetch_done;

    modport core (
        output dside_master_address, dside_master_byte_enables, dside_master_lock,
        output dside_master_write_data, dside_master_request,
        output dside_master_read_not_write, dside_master_select, dside_master_sequential,
        input  dside_read_data_in, dside_error_ack_in, dside_grant_in, dside_retry_in,
        input  dside_timeout_in, dside_transfer_ack_in,
        output fside_master_address, fside_master_byte_enables, fside_master_lock,
        output fside_master_write_data, fside_master_request,
        output fside_master_read_not_write, fside_master_select, fside_master_sequential,
        input  fside_read_data_in, fside_error_ack_in, fside_grant_in, fside_retry_in,
        input  fside_timeout_in, fside_transfer_ack_in,
        output local_data_address, local_data_byte_enables, local_data_write,
        output local_data_addr_strobe, local_data_read_strobe, local_data_write_strobe,
        input  local_data_read, local_data_done,
        output local_fetch_address, local_fetch_addr_strobe, local_fetch_in_progress,
        input  local_fetch_instr, local_fetch_done
    );
    modport fabric (
        input  dside_master_address, dside_master_byte_enables, dside_master_lock,
        input  dside_master_write_data, dside_master_request,
        input  dside_master_read_not_write, dside_master_select, dside_master_sequential,
        output dside_read_data_in, dside_error_ack_in, dside_grant_in, dside_retry_in,
        output dside_timeout_in, dside_transfer_ack_in,
        input  fside_master_address, fside_master_byte_enables, fside_master_lock,
        input  fside_master_write_data, fside_master_request,
        input  fside_master_read_not_write, fside_master_select, fside_master_sequential,
        output fside_read_data_in, fside_error_ack_in, fside_grant_in, fside_retry_in,
        output fside_timeout_in, fside_transfer_ack_in,
        input  local_data_address, local_data_byte_enables, local_data_write,
        input  local_data_addr_strobe, local_data_read_strobe, local_data_write_strobe,
        output local_data_read, local_data_done,
        input  local_fetch_address, local_fetch_addr_strobe, local_fetch_in_progress,
        output local_fetch_instr, local_fetch_done
    );
endinterface

//--- src/cbm_pkg.sv
// How it works
// R1: Separate data and fetch peripheral master ports
// R2: Peripheral masters size transfers by byte enables
// R3: Fetch peripheral write data always zero
// R4: Fetch peripheral read-not-write tied to one
// R5: Write data bus separate from read data
// R6: Interconnect may OR buses for monitor
// R7: Shared slave arbitrates both peripheral ports
// R8: Local bus synchronous to core clock
// R9: Immediate memory completes access in one cycle (data side here: local_data_done a cycle after the strobe)
// R10: All local bus signals active high
// R11: Local address valid only with strobe
// R12: Byte enables valid only with strobe
// R13: Byte enable bit zero is top lane
// R14: Fetch local port: fetch strobe, no writes
// R15: Debug reset and break inputs accepted
// R16: Address strobe only in first cycle
// R17: Memory ready ends transfer, data valid (fetch side here: local_fetch_instr arrives one cycle after local_fetch_done)
// R18: Read/write strobe held until after ready
// R19: Write data held until after ready
package cbm_pkg;
    localparam int          ADDR_W     = 32;
    localparam int          DATA_W     = 32;
    localparam int          BE_W       = 4;
    localparam logic [31:0] FETCH_WDATA = 32'h0000_0000;
    localparam logic        FETCH_RNW   = 1'h1;
    localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
    localparam logic [3:0]  BE_NONE     = 4'h0;
    localparam logic [3:0]  BE_WORD     = 4'hF;

    // Legal lane patterns; bit 3 of the vector is lane 0, the top byte
    function automatic logic cbm_be_legal(input logic [3:0] be);
        case (be)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: cbm_be_legal = 1'b1;
            default: cbm_be_legal = 1'b0;
        endcase
    endfunction
endpackage

//--- test/cbm_asserts.sv
module cbm_asserts
    import cbm_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Watched bus signals
    input wire logic [DATA_W-1:0] f_wdata,
    input wire logic              f_rnw,
    input wire logic [BE_W-1:0]   d_be,
    input wire logic              d_as,
    input wire logic              d_rs,
    input wire logic              d_ws,
    input wire logic              d_done,
    input wire logic              f_as,
    input wire logic              f_fetch
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Bus checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_fetch_wdata_zero: assert property (f_wdata == 32'h0000_0000)
        else $error("fetch write data not zero");
    chk_fetch_rnw_one: assert property (f_rnw)
        else $error("fetch rnw not one");
    chk_strobe_one_cycle: assert property (d_as |=> !d_as)
        else $error("address strobe longer than one cycle");
    chk_rw_start: assert property (($rose(d_rs) || $rose(d_ws)) |-> d_as)
        else $error("rw strobe rose without address strobe");
    chk_rw_held: assert property ((d_rs || d_ws) && !d_done |=> $stable({d_rs, d_ws}))
        else $error("rw strobe dropped before done");
    chk_rw_release: assert property (d_done ##1 !d_as |-> !(d_rs || d_ws))
        else $error("rw strobe held after done");
    chk_be_legal: assert property (d_as |-> d_be
        inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
        else $error("illegal byte enables");
    chk_done_bound: assert property (d_as |-> ##[0:4] d_done)
        else $error("local transfer not done");
    chk_fetch_strobe: assert property (f_as |-> f_fetch)
        else $error("fetch strobe without fetch");
endmodule

//--- test/cpu_bus_master_ports_test.sv
module cpu_bus_master_ports_test
    import cbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Stimulus and checks
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              dp_req, dp_rnw, dp_lock, dp_seq, fp_req, dl_req, dl_rnw, fl_req;
    logic [ADDR_W-1:0] dp_addr, fp_addr, dl_addr, fl_addr;
    logic [BE_W-1:0]   dp_be, dl_be;
    logic [DATA_W-1:0] dp_wdata, dl_wdata;
    logic [ADDR_W-1:0] ra;
    logic              dl_ready, fl_ready, dp_busy, fp_busy;
    logic [68:0]       dq[$], pq[$], fq[$], lq[$];
    logic [3:0]        legal[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
    int                num_errors = 0;
    int                tests_run = 0;
    cbm_if bus_if (.clk(clk), .rst(rst));
    cbm_core_ports cbm_core_ports_i (.clk, .rst, .debug_reset_in(1'b0),
        .external_break_in(1'b0), .external_nonmaskable_break_in(1'b0), .interrupt_in(1'b0),
        .bus(bus_if.core), .dp_req, .dp_rnw, .dp_lock, .dp_seq, .dp_addr, .dp_be, .dp_wdata,
        .dp_busy, .dp_done(), .dp_err(), .dp_rdata(), .fp_req, .fp_addr, .fp_busy, .fp_done(),
        .fp_err(), .fp_rdata(), .dl_req, .dl_rnw, .dl_addr, .dl_be, .dl_wdata, .dl_ready,
        .dl_done(), .dl_rdata(), .fl_req, .fl_addr, .fl_ready, .fl_done(), .fl_rdata(),
        .halt_pending(), .irq_seen());
    cbm_fabric_end cbm_fabric_end_i (.clk, .rst, .bus(bus_if.fabric), .mem_we(),
        .mem_addr(), .mem_be(), .mem_wdata(), .mem_rdata(32'h0000_0000), .monitor_data());
    cbm_asserts cbm_asserts_i (.clk, .rst, .f_wdata(bus_if.fside_master_write_data),
        .f_rnw(bus_if.fside_master_read_not_write), .d_be(bus_if.local_data_byte_enables),
        .d_as(bus_if.local_data_addr_strobe), .d_rs(bus_if.local_data_read_strobe),
        .d_ws(bus_if.local_data_write_strobe), .d_done(bus_if.local_data_done),
        .f_as(bus_if.local_fetch_addr_strobe), .f_fetch(bus_if.local_fetch_in_progress));
    task automatic chk(string n, logic [68:0] s, logic [68:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Each driver notes the expectation when it raises the request
    task automatic dl_go(logic r, logic [31:0] a, logic [3:0] b, logic [31:0] d);
        @(posedge clk);
        {dl_req, dl_rnw, dl_addr, dl_be, dl_wdata} <= {1'b1, r, a, b, d};
        dq.push_back({r, a, b, r ? 32'h0 : d});
        do @(posedge clk); while (!dl_ready);
        dl_req <= 1'b0;
    endtask
    task automatic dp_go(logic r, logic [31:0] a, logic [3:0] b, logic [31:0] d);
        @(posedge clk);
        {dp_req, dp_rnw, dp_addr, dp_be, dp_wdata, dp_seq} <= {1'b1, r, a, b, d, 1'b0};
        pq.push_back({r, a, b, r ? 32'h0 : d});
        @(posedge clk);
        dp_req <= 1'b0;
        do @(posedge clk); while (dp_busy);
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        {dp_req, dp_rnw, dp_lock, dp_seq, fp_req, dl_req, dl_rnw, fl_req} = '0;
        {dp_addr, fp_addr, dl_addr, fl_addr, dp_be, dl_be, dp_wdata, dl_wdata} = '0;
        void'($urandom(40));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (legal[i]) dl_go(i[0], $urandom & 32'h3FC, legal[i], $urandom);
        @(posedge clk);
        {dl_req, dl_be} <= {1'b1, 4'h5};
        repeat (4) @(posedge clk);
        dl_req <= 1'b0;
        $display("test local data done");
        foreach (legal[i]) dp_go(i[1], $urandom & 32'h3FC, legal[i], $urandom);
        $display("test peripheral data done");
        repeat (3) begin
            @(posedge clk);
            ra = $urandom & 32'h3FC;
            {fp_req, fp_addr} <= {1'b1, ra};
            fq.push_back({1'b1, ra, 4'hF, 32'h0});
            do @(posedge clk); while (fp_busy);
            fp_req <= 1'b0;
            do @(posedge clk); while (fp_busy);
            ra = $urandom & 32'h3FC;
            {fl_req, fl_addr} <= {1'b1, ra};
            lq.push_back({1'b1, ra, 4'h0, 32'h0});
            do @(posedge clk); while (!fl_ready);
            fl_req <= 1'b0;
        end
        repeat (8) @(posedge clk);
        $display("test fetch done");
        chk("left", dq.size() + pq.size() + fq.size() + lq.size(), 0);
        test_done();
    end
    always @(posedge clk) if (!rst) begin
        if (bus_if.local_data_addr_strobe) chk("dl", {bus_if.local_data_read_strobe,
            bus_if.local_data_address, bus_if.local_data_byte_enables,
            bus_if.local_data_read_strobe ? 32'h0 : bus_if.local_data_write}, dq.pop_front());
        if ($rose(bus_if.dside_master_select)) chk("dp", {bus_if.dside_master_read_not_write,
            bus_if.dside_master_address, bus_if.dside_master_byte_enables,
            bus_if.dside_master_write_data}, pq.pop_front());
        if ($rose(bus_if.fside_master_select)) chk("fp", {bus_if.fside_master_read_not_write,
            bus_if.fside_master_address, bus_if.fside_master_byte_enables,
            bus_if.fside_master_write_data}, fq.pop_front());
        if (bus_if.local_fetch_addr_strobe) chk("fl", {bus_if.local_fetch_in_progress,
            bus_if.local_fetch_address, 36'h0}, lq.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule
